// ---- logic/ptc_defs.svh ----
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH
// Overview of operation
// - nine bits: accept, net1 four, net0 four
// - register sits at byte address 0x010, word index 0x004
// - new value reaches switches after command completes
// - net1 lock blocks net1 field writes
// - net0 lock blocks net0 field writes
// - power-on or brown-out loads all ones
// - accept bit gates general call acceptance
// - each terminal bit connects or disconnects
// - one or two networks, 7 or 8 bits
// - shutdown low: A open, wiper to B
// - shutdown overrides but keeps terminal bits
// - locks mirror nonvolatile copy, not writable
`define PTC_CTRL_INDEX    10'h004
`define PTC_CTRL_ADDR     12'h010
`define PTC_NETS          2
`define PTC_NET_BITS      4
`define PTC_WIDTH         9
`define PTC_RESET         9'h1FF
`define PTC_GC_BIT        8
`define PTC_NET1_HI       7
`define PTC_NET1_LO       4
`define PTC_NET0_HI       3
`define PTC_NET0_LO       0
`define PTC_SHDN_OFS      3
`define PTC_A_OFS         2
`define PTC_W_OFS         1
`define PTC_B_OFS         0
`define PTC_ADDR_LO       2
`define PTC_ADDR_HI       11
`endif

// ---- logic/ptc_pkg.sv ----
`include "ptc_defs.svh"
package ptc_pkg;
  typedef enum logic [1:0] {PTC_IDLE, PTC_ACCESS, PTC_COMMIT} ptc_state_t;
  typedef logic [3:0] ptc_net_t;
endpackage : ptc_pkg

// ---- logic/ptc_net_switch.sv ----
`timescale 1ns/1ns
`include "ptc_defs.svh"
// one network: terminal bits plus shutdown become switch enables
module ptc_net_switch
  import ptc_pkg::*;
(
  // control nibble
  input  wire ptc_net_t ctrl,
  input  wire logic     present,
  // switch enables
  output logic          sw_a,
  output logic          sw_w,
  output logic          sw_b,
  output logic          sw_wb_short
);
  // shutdown overrides terminals without touching stored bits
  always_comb begin
    if (!present) begin
      sw_a        = 1'b0;
      sw_w        = 1'b0;
      sw_b        = 1'b0;
      sw_wb_short = 1'b0;
    end else if (!ctrl[`PTC_SHDN_OFS]) begin
      sw_a        = 1'b0;
      sw_w        = 1'b0;
      sw_b        = 1'b0;
      sw_wb_short = 1'b1;
    end else begin
      sw_a        = ctrl[`PTC_A_OFS];
      sw_w        = ctrl[`PTC_W_OFS];
      sw_b        = ctrl[`PTC_B_OFS];
      sw_wb_short = 1'b0;
    end
  end
endmodule : ptc_net_switch

// ---- logic/ptc_top.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "ptc_defs.svh"
// terminal connect control register over APB
module ptc_top
  import ptc_pkg::*;
#(
  parameter bit DUAL = 1'b1
)(
  // clock and reset (reset also covers brown-out)
  input  wire logic        clock,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // nonvolatile lock copies
  input  wire logic        net0_lock,
  input  wire logic        net1_lock,
  // general call request from bus front end
  input  wire logic        general_call_seen,
  output logic             general_call_take,
  // switch enables
  output logic             net0_terminal_a_pin,
  output logic             net0_wiper_pin,
  output logic             net0_terminal_b_pin,
  output logic             net0_shutdown_short,
  output logic             net1_terminal_a_pin,
  output logic             net1_wiper_pin,
  output logic             net1_terminal_b_pin,
  output logic             net1_shutdown_short
);
  // bus handshake state
  ptc_state_t            state_reg, state_next;
  logic [31:0]           prdata_reg, prdata_next;
  logic                  pready_reg, pready_next;
  logic                  perr_reg, perr_next;

  // written copy, and the copy that drives the switches; two copies
  // so a command in flight never shows on the network
  logic [`PTC_WIDTH-1:0] ctrl_reg, ctrl_next;
  logic [`PTC_WIDTH-1:0] live_reg, live_next;

  // output flops, one bit per network
  logic [`PTC_NETS-1:0]  pin_a_reg, pin_a_next;
  logic [`PTC_NETS-1:0]  pin_w_reg, pin_w_next;
  logic [`PTC_NETS-1:0]  pin_b_reg, pin_b_next;
  logic [`PTC_NETS-1:0]  short_reg, short_next;
  logic                  gc_reg, gc_next;

  // decoded switch enables ahead of the output flops
  logic [`PTC_NETS-1:0]  dec_a;
  logic [`PTC_NETS-1:0]  dec_w;
  logic [`PTC_NETS-1:0]  dec_b;
  logic [`PTC_NETS-1:0]  dec_s;
  logic [`PTC_NETS-1:0]  net_present;

  // access qualifiers
  logic                  hit;
  logic                  in_access;
  logic                  in_commit;
  logic                  wr_hit;
  logic                  rd_hit;

  // address decode on word index; low byte lanes are not decoded,
  // so an unaligned offset inside the word still hits
  always_comb begin
    if (paddr[`PTC_ADDR_HI:`PTC_ADDR_LO] == `PTC_CTRL_INDEX) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // qualifiers of the access and commit cycles
  assign in_access = (state_reg == PTC_ACCESS);
  assign in_commit = (state_reg == PTC_COMMIT);
  assign wr_hit    = in_access && hit && pwrite;
  assign rd_hit    = in_access && hit && !pwrite;

  // handshake: one wait state, then a commit cycle that carries pready
  // to the master; a setup that falls in the commit cycle is not seen
  always_comb begin
    state_next  = state_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    perr_next   = 1'b0;
    case (state_reg)
      PTC_IDLE: begin
        // wait for a setup cycle
        if (psel && !penable) begin
          state_next = PTC_ACCESS;
        end
      end
      PTC_ACCESS: begin
        pready_next = 1'b1;
        perr_next   = !hit;
        prdata_next = '0;
        if (rd_hit) begin
          prdata_next = 32'(ctrl_reg);
        end
        state_next = PTC_COMMIT;
      end
      PTC_COMMIT: begin
        state_next = PTC_IDLE;
      end
      default: begin
        state_next = PTC_IDLE;
      end
    endcase
  end

  // handshake flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg  <= PTC_IDLE;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      perr_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      perr_reg   <= perr_next;
    end
  end

  // register write; a locked network keeps its nibble, the accept
  // bit has no lock of its own and always takes the new value
  always_comb begin
    ctrl_next = ctrl_reg;
    live_next = live_reg;
    if (wr_hit) begin
      ctrl_next[`PTC_GC_BIT] = pwdata[`PTC_GC_BIT];
      if (!net1_lock) begin
        ctrl_next[`PTC_NET1_HI:`PTC_NET1_LO] =
          pwdata[`PTC_NET1_HI:`PTC_NET1_LO];
      end
      if (!net0_lock) begin
        ctrl_next[`PTC_NET0_HI:`PTC_NET0_LO] =
          pwdata[`PTC_NET0_HI:`PTC_NET0_LO];
      end
    end
    // switches follow only after the command has finished, so a
    // half-done transfer never reaches the network
    if (in_commit) begin
      live_next = ctrl_reg;
    end
  end

  // register flops; locks are plain inputs, no bus write reaches them
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `PTC_RESET;
      live_reg <= `PTC_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      live_reg <= live_next;
    end
  end

  // net1 is storage only on single-network parts
  assign net_present = {DUAL, 1'b1};

  // one switch decoder per network; the loop keeps both networks
  // identical so a change to one cannot miss the other
  for (genvar g = 0; g < `PTC_NETS; g++) begin : g_net
    ptc_net_switch ptc_net_switch_i (
      .ctrl        (live_reg[g*`PTC_NET_BITS +: `PTC_NET_BITS]),
      .present     (net_present[g]),
      .sw_a        (dec_a[g]),
      .sw_w        (dec_w[g]),
      .sw_b        (dec_b[g]),
      .sw_wb_short (dec_s[g])
    );
  end

  // output flop inputs; general call is gated by the live accept bit
  always_comb begin
    pin_a_next = dec_a;
    pin_w_next = dec_w;
    pin_b_next = dec_b;
    short_next = dec_s;
    gc_next    = general_call_seen && live_reg[`PTC_GC_BIT];
  end

  // output flops; switches stay open while reset is held, which costs
  // one cycle before the all-connected state shows after release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_a_reg <= '0;
      pin_w_reg <= '0;
      pin_b_reg <= '0;
      short_reg <= '0;
      gc_reg    <= 1'b0;
    end else begin
      pin_a_reg <= pin_a_next;
      pin_w_reg <= pin_w_next;
      pin_b_reg <= pin_b_next;
      short_reg <= short_next;
      gc_reg    <= gc_next;
    end
  end

  // bus and general call ports straight from flops
  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = perr_reg;
  assign general_call_take   = gc_reg;

  // switch pins, network 0 then network 1
  assign net0_terminal_a_pin = pin_a_reg[0];
  assign net0_wiper_pin      = pin_w_reg[0];
  assign net0_terminal_b_pin = pin_b_reg[0];
  assign net0_shutdown_short = short_reg[0];
  assign net1_terminal_a_pin = pin_a_reg[1];
  assign net1_wiper_pin      = pin_w_reg[1];
  assign net1_terminal_b_pin = pin_b_reg[1];
  assign net1_shutdown_short = short_reg[1];
endmodule : ptc_top

// ---- sim/ptc_props.sv ----
`timescale 1ns/1ns
`include "ptc_defs.svh"
module ptc_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // general call and net0 switches
  input wire logic        general_call_seen,
  input wire logic        general_call_take,
  input wire logic        net0_terminal_a_pin,
  input wire logic        net0_shutdown_short
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // one wait state, then a single-cycle answer
  a_ready_late: assert property ($rose(psel)
    |-> (!pready)[*2] ##1 pready) else $error("pready timing wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_bad_addr: assert property (pready && paddr != `PTC_CTRL_ADDR
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_good_addr: assert property (pready && paddr == `PTC_CTRL_ADDR
    |-> !pslverr) else $error("mapped access refused");
  a_upper_zero: assert property (pready |-> prdata[31:9] == 23'h0)
    else $error("upper read bits set");
  a_gc_cause: assert property (general_call_take
    |-> $past(general_call_seen)) else $error("general call uncaused");
  a_shdn_open: assert property (net0_shutdown_short
    |-> !net0_terminal_a_pin) else $error("a closed in shutdown");
  // switches move only after a completed command or a reset
  a_pin_commit: assert property ($changed({net0_terminal_a_pin,
    net0_shutdown_short}) |-> $past(pready, 2) || $past(pready, 3)
    || $past(reset, 2) || $past(reset, 3)) else $error("early switch");
  cover property (pslverr);
  cover property (general_call_take);
  cover property (net0_shutdown_short);
endmodule : ptc_props
bind ptc_top ptc_props ptc_props_i (.clock, .reset, .psel, .paddr,
  .prdata, .pready, .pslverr, .general_call_seen, .general_call_take,
  .net0_terminal_a_pin, .net0_shutdown_short);

// ---- sim/ptc_host.sv ----
`timescale 1ns/1ns
module ptc_host (
  // clock
  input  wire logic        clock,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int fails = 0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // one transfer; the slave commit cycle ends on the edge that samples pready, before the idle edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!pready && n < 20);
    if (!pready) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer
endmodule : ptc_host

// ---- sim/pot_terminal_control_tb.sv ----
`timescale 1ns/1ns
`include "ptc_defs.svh"
module pot_terminal_control_tb;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, err;
  logic net0_lock, net1_lock, general_call_seen, general_call_take;
  logic net0_terminal_a_pin, net0_wiper_pin, net0_terminal_b_pin;
  logic net1_terminal_a_pin, net1_wiper_pin, net1_terminal_b_pin;
  logic net0_shutdown_short, net1_shutdown_short;
  logic s1a, s1w, s1b, s1s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_errors = 0;
  int checks_done = 0;
  // rows: {net1 lock, net0 lock, data written}, value read back
  logic [10:0] wrow [5] = '{11'h0A5, 11'h3FF, 11'h400, 11'h755, 11'h1EE};
  logic [8:0]  erow [5] = '{9'h0A5, 9'h1F5, 9'h0F0, 9'h1F0, 9'h1EE};
  // w and b are don't-care while shutdown ties them
  wire [3:0] pin0 = {net0_terminal_a_pin, net0_shutdown_short ? 2'b00 :
    {net0_wiper_pin, net0_terminal_b_pin}, net0_shutdown_short};
  wire [3:0] pin1 = {net1_terminal_a_pin, net1_shutdown_short ? 2'b00 :
    {net1_wiper_pin, net1_terminal_b_pin}, net1_shutdown_short};
  ptc_top ptc_top_i (.*);
  ptc_host ptc_host_i (.*);
  // single-network build: net1 bits must reach no switch
  if (1) begin : g_single
    ptc_top #(.DUAL(1'b0)) ptc_top_i (
      .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata (), .pready (), .pslverr (), .net0_lock, .net1_lock,
      .general_call_seen, .general_call_take (),
      .net0_terminal_a_pin (), .net0_wiper_pin (), .net0_terminal_b_pin (),
      .net0_shutdown_short (), .net1_terminal_a_pin (s1a),
      .net1_wiper_pin (s1w), .net1_terminal_b_pin (s1b),
      .net1_shutdown_short (s1s));
  end
  function logic [3:0] expn(input logic [3:0] n);
    return n[3] ? {n[2:0], 1'b0} : 4'h1;
  endfunction : expn
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [8:0] v);
    ptc_host_i.xfer(1'b1, a, {23'h0, v}, rd, err);
    if (ptc_host_i.fails != 0) summarize();
  endtask : wr
  task rdc(input logic [8:0] v);
    ptc_host_i.xfer(1'b0, `PTC_CTRL_ADDR, 32'h0, rd, err);
    if (ptc_host_i.fails != 0) summarize();
    chk(rd, {23'h0, v});
  endtask : rdc
  task summarize;
    n_errors += ptc_host_i.fails;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    reset = 1'b1;
    {net0_lock, net1_lock, general_call_seen} = 3'h0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rdc(9'h1FF);
    foreach (wrow[i]) begin
      {net1_lock, net0_lock} <= wrow[i][10:9];
      wr(`PTC_CTRL_ADDR, wrow[i][8:0]);
      rdc(erow[i]);
      repeat (2) @(posedge clock);
      chk(pin0, expn(erow[i][3:0]));
      chk(pin1, expn(erow[i][7:4]));
      chk({s1a, s1w, s1b, s1s}, 4'h0);
      $display("row %0d done", i);
    end
    general_call_seen <= 1'b1;
    repeat (2) @(posedge clock);
    chk(general_call_take, 1'b1);
    wr(`PTC_CTRL_ADDR, 9'h0FF);
    repeat (2) @(posedge clock);
    chk(general_call_take, 1'b0);
    wr(12'h014, 9'h000);
    chk(err, 1'b1);
    rdc(9'h0FF);
    $display("general call and unmapped done");
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdc(9'h1FF);
    wr(`PTC_CTRL_ADDR, 9'h0A5);
    rdc(9'h0A5);
    $display("second reset done");
    summarize();
  end
endmodule : pot_terminal_control_tb
